// >>> include/manual_mv_pkg.sv
// package for the manual mv control block: register map, field codes,
// mv range limits in tenths of a percent, bus response codes.
// assumes a 32-bit axi4-lite master and signed 16-bit mv values.
package manual_mv_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] MANMV_OFS  = 8'h04;
  localparam logic [7:0] LIMIT_OFS  = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;
  // ==========================================================
  // control register bit positions
  localparam int CTRL_MANUAL_REQ   = 0;
  localparam int CTRL_SEL_ENABLE   = 1;
  localparam int CTRL_PID_MODE     = 2;
  localparam int CTRL_LIMIT_ENABLE = 3;
  localparam int CTRL_DIRECT_POS   = 4;
  localparam int CTRL_FLOATING     = 5;
  localparam int CTRL_HEAT_COOL    = 6;
  localparam int CTRL_VALVE        = 7;
  localparam int CTRL_KEY_UP       = 8;
  localparam int CTRL_KEY_DOWN     = 9;
  localparam logic [9:0] CTRL_RESET = 10'h00A; // select enable and limit enable on
  // ==========================================================
  // mv values in 0.1 percent units
  localparam logic signed [15:0] MV_STD_MIN  = 16'shFFCE; // -5.0
  localparam logic signed [15:0] MV_STD_MAX  = 16'sh041A; // 105.0
  localparam logic signed [15:0] MV_HC_MIN   = 16'shFBE6; // -105.0
  localparam logic signed [15:0] MV_OPEN_THR = 16'sh03E8; // 100.0
  localparam logic signed [15:0] MV_ZERO     = 16'sh0000;
  localparam logic signed [15:0] MV_RAMP_STEP = 16'sh0001;
  localparam logic [15:0] LIM_HI_RESET = 16'h03E8;
  localparam logic [15:0] LIM_LO_RESET = 16'h0000;
  // ==========================================================
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> hw/manual_mv_control.sv
// manual mv control: auto/manual selection, bumpless ramp, valve drives.
// assumes one 125 MHz clock, axi4-lite register access, keys as control
// register bits, feedback error synchronised here, auto mv from the same clock domain.
//
// Functional notes
// [R1] entering manual seeds the manual mv with the last automatic mv
// [R2] manual mv writes take effect on the output immediately
// [R3] manual mode only allowed under pid control, never on/off
// [R4] display auto-return is suppressed while manual
// [R5] on any mode switch output starts at old mv, then ramps to target
// [R6] manual mode and mv are kept across a power loss
// [R7] floating or direct-off valve: up key opens, down key closes
// [R8] closed control or direct-on valve: manual mv is numeric
// [R9] feedback error, limit off: open at >=100, close at <=0
// [R10] feedback error, limit on: open at upper, close at lower limit
// [R11] manual mv range -5..105, or -105..105 for heating/cooling
// [R12] with limiting on, manual mv clamps to lower/upper mv limits
// [R13] direct-off valve mv is open, hold or closed; direct-on numeric
// [R14] mode switching only while select enable is on; clearing pid mode still forces manual off
// [R15] limiting off ignores mv limits; limiting defaults on
// [R16] manual mv wins even while the program is in reset
// [R17] entering manual aborts auto-tuning
// [R18] program segment timing keeps running in manual
// [R19] open and close are never driven together
//
// The AXI4-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
module manual_mv_control
  import manual_mv_pkg::*;
#(
  parameter int MV_W = 16
) (
  // clock, reset, enable
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  // axi4-lite slave
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // process side
  input  wire logic signed [MV_W-1:0] auto_mv,
  input  wire logic              feedback_err_pin,
  input  wire logic              power_restored,
  input  wire logic              program_reset,
  input  wire logic              autotune_active,
  // outputs
  output logic signed [MV_W-1:0] mv_out,
  output logic                   valve_open,
  output logic                   valve_close,
  output logic                   manual_active,
  output logic                   display_return_en,
  output logic                   autotune_abort,
  output logic                   segment_timer_run
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [9:0]             ctrl;
    logic signed [MV_W-1:0] man_mv;
    logic signed [MV_W-1:0] lim_hi;
    logic signed [MV_W-1:0] lim_lo;
    logic signed [MV_W-1:0] out_mv;
    logic                   manual;
    logic                   ramping;
    logic                   open;
    logic                   close;
    logic                   abort;
    logic [2:0]             err_sync;
    logic                   err;
    logic                   aw_have;
    logic [7:0]             aw_addr;
    logic                   w_have;
    logic [31:0]            w_data;
    logic [3:0]             w_strb;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic signed [MV_W-1:0] lo_bound;
  logic signed [MV_W-1:0] hi_bound;
  logic signed [MV_W-1:0] wr_mv;
  logic signed [MV_W-1:0] clamp_mv;
  logic signed [MV_W-1:0] target;
  logic                   err_now;
  logic                   want_manual;
  logic                   do_write;
  logic                   key_mode;
  logic                   o_req;
  logic                   c_req;

  // ==========================================================
  // range of the manual mv for the current configuration
  always_comb begin
    if (s_q.ctrl[CTRL_LIMIT_ENABLE]) begin
      lo_bound = s_q.lim_lo; // [R12]
      hi_bound = s_q.lim_hi;
    end else begin
      lo_bound = s_q.ctrl[CTRL_HEAT_COOL] ? MV_HC_MIN : MV_STD_MIN; // [R11] [R15]
      hi_bound = MV_STD_MAX;
    end
    wr_mv = s_q.w_data[MV_W-1:0];
    if (wr_mv < lo_bound) begin
      clamp_mv = lo_bound;
    end else if (wr_mv > hi_bound) begin
      clamp_mv = hi_bound;
    end else begin
      clamp_mv = wr_mv;
    end
  end

  assign err_now  = s_q.err; // settled level of the synchronised pin
  assign do_write = s_q.aw_have & s_q.w_have & ~s_q.bvalid;
  // valve keys drive relays only when the mv is not numeric
  assign key_mode = s_q.ctrl[CTRL_VALVE] &
                    (s_q.ctrl[CTRL_FLOATING] | ~s_q.ctrl[CTRL_DIRECT_POS]);

  // ==========================================================
  // next-state logic
  always_comb begin
    s_d = s_q;
    s_d.err_sync = {s_q.err_sync[1:0], feedback_err_pin};
    // flag moves only once the second and third stages agree
    if (s_q.err_sync[1] == s_q.err_sync[2]) begin
      s_d.err = s_q.err_sync[2];
    end
    s_d.abort = 1'b0;
    // bus channel capture
    if (s_axi_awvalid && !s_q.aw_have) begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w_have) begin
      s_d.w_have = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (do_write) begin
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = RESP_OKAY;
      // partial strobes are taken as full words: fields are not byte aligned
      unique case (s_q.aw_addr)
        CTRL_OFS: s_d.ctrl = s_q.w_data[9:0];
        MANMV_OFS: begin
          if (s_q.manual && !key_mode) begin
            s_d.man_mv = clamp_mv; // [R2] [R8] [R11] [R12]
          end
        end
        LIMIT_OFS: begin
          s_d.lim_lo = s_q.w_data[MV_W-1:0];
          s_d.lim_hi = s_q.w_data[31:16];
        end
        default: s_d.bresp = RESP_SLVERR;
      endcase
    end
    // read channel
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = RESP_OKAY;
      unique case (s_axi_araddr)
        CTRL_OFS:   s_d.rdata = {22'h0, s_q.ctrl};
        MANMV_OFS:  s_d.rdata = {{(32-MV_W){s_q.man_mv[MV_W-1]}}, s_q.man_mv};
        LIMIT_OFS:  s_d.rdata = {s_q.lim_hi, s_q.lim_lo};
        STATUS_OFS: s_d.rdata = {16'h0000, s_q.out_mv[7:0], 3'h0, err_now,
                                 s_q.close, s_q.open, s_q.ramping, s_q.manual};
        default: begin
          s_d.rdata = 32'h00000000;
          s_d.rresp = RESP_SLVERR;
        end
      endcase
    end
    // mode switching, manual mode kept through power restore
    want_manual = s_q.ctrl[CTRL_MANUAL_REQ] & s_q.ctrl[CTRL_PID_MODE]; // [R3]
    if (s_q.ctrl[CTRL_SEL_ENABLE] && (want_manual != s_q.manual)) begin // [R14]
      s_d.manual  = want_manual;
      s_d.ramping = 1'b1; // [R5] out_mv holds the pre-switch value
      if (want_manual) begin
        s_d.man_mv = s_q.out_mv; // [R1] out_mv equals last auto mv
        s_d.abort  = autotune_active; // [R17]
      end
    end else if (!s_q.ctrl[CTRL_PID_MODE] && s_q.manual) begin
      s_d.manual = 1'b0; // [R3]
      s_d.ramping = 1'b1; // [R5] a forced exit ramps as well
    end
    // power restore does not touch manual or man_mv [R6]
    // output mv: manual has priority over program reset [R16]
    target = s_q.manual ? s_q.man_mv : auto_mv;
    if (s_d.manual != s_q.manual) begin
      s_d.out_mv = s_q.out_mv; // [R5] old mv stands on the switch edge
    end else if (s_q.manual && !s_q.ramping) begin
      s_d.out_mv = s_q.man_mv; // [R2]
    end else if (!s_q.ramping) begin
      s_d.out_mv = auto_mv;
    end else if (s_q.out_mv < target) begin
      s_d.out_mv = s_q.out_mv + MV_RAMP_STEP; // [R5]
    end else if (s_q.out_mv > target) begin
      s_d.out_mv = s_q.out_mv - MV_RAMP_STEP; // [R5]
    end else begin
      s_d.ramping = 1'b0;
    end
    // valve drives
    o_req = 1'b0;
    c_req = 1'b0;
    if (s_q.ctrl[CTRL_VALVE] && s_q.manual) begin
      if (err_now) begin
        if (s_q.ctrl[CTRL_LIMIT_ENABLE]) begin
          o_req = (s_q.man_mv == s_q.lim_hi); // [R10]
          c_req = (s_q.man_mv == s_q.lim_lo); // [R10]
        end else begin
          o_req = (s_q.man_mv >= MV_OPEN_THR); // [R9]
          c_req = (s_q.man_mv <= MV_ZERO);     // [R9]
        end
      end else if (key_mode) begin
        o_req = s_q.ctrl[CTRL_KEY_UP];   // [R7] [R13] open/hold/closed
        c_req = s_q.ctrl[CTRL_KEY_DOWN]; // [R7]
      end
    end
    s_d.open  = o_req & ~c_req; // [R19]
    s_d.close = c_req & ~o_req; // [R19]
  end

  // ==========================================================
  // state register; synchronous reset wins over ce, ce low freezes all other updates
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.ctrl   <= CTRL_RESET; // [R15]
      s_q.lim_hi <= LIM_HI_RESET;
      s_q.lim_lo <= LIM_LO_RESET;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs
  assign s_axi_awready     = ~s_q.aw_have;
  assign s_axi_wready      = ~s_q.w_have;
  assign s_axi_bvalid      = s_q.bvalid;
  assign s_axi_bresp       = s_q.bresp;
  assign s_axi_arready     = ~s_q.rvalid;
  assign s_axi_rvalid      = s_q.rvalid;
  assign s_axi_rdata       = s_q.rdata;
  assign s_axi_rresp       = s_q.rresp;
  assign mv_out            = s_q.out_mv;
  assign valve_open        = s_q.open;
  assign valve_close       = s_q.close;
  assign manual_active     = s_q.manual;
  assign display_return_en = ~s_q.manual; // [R4]
  assign autotune_abort    = s_q.abort;
  assign segment_timer_run = ~program_reset; // [R18] independent of manual

  // ==========================================================
  // checks
  // ce in an antecedent is the one sampled at the edge that moves the state
  chk_no_both_drive: assert property (@(posedge aclk) disable iff (!aresetn) // [R19]
    !(valve_open && valve_close)) else $error("open and close together");
  chk_seed_manual: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
    ce && $rose(s_q.manual) |-> s_q.man_mv == $past(s_q.out_mv))
    else $error("manual mv not seeded");
  chk_pid_only: assert property (@(posedge aclk) disable iff (!aresetn) // [R3]
    ce && !s_q.ctrl[CTRL_PID_MODE] |=> !s_q.manual || !ce)
    else $error("manual without pid");
  chk_display_hold: assert property (@(posedge aclk) disable iff (!aresetn) // [R4]
    manual_active |-> !display_return_en) else $error("display return in manual");
  chk_bump_start: assert property (@(posedge aclk) disable iff (!aresetn) // [R5]
    ce && $changed(s_q.manual) |-> mv_out == $past(mv_out) || !$past(ce))
    else $error("mv stepped on switch");
  chk_ramp_step: assert property (@(posedge aclk) disable iff (!aresetn) // [R5]
    s_q.ramping && $past(s_q.ramping) && $past(ce) |->
    (mv_out - $past(mv_out)) inside {16'sh0000, 16'sh0001, 16'shFFFF})
    else $error("ramp step too big");
  chk_sel_gate: assert property (@(posedge aclk) disable iff (!aresetn) // [R14]
    ce && !s_q.ctrl[CTRL_SEL_ENABLE] && s_q.ctrl[CTRL_PID_MODE] |=>
    $stable(s_q.manual) || $changed(s_q.ctrl)) else $error("switch while disabled");
  chk_err_open: assert property (@(posedge aclk) disable iff (!aresetn) // [R9]
    ce && s_q.ctrl[CTRL_VALVE] && s_q.manual && err_now &&
    !s_q.ctrl[CTRL_LIMIT_ENABLE] && s_q.man_mv >= MV_OPEN_THR |=> valve_open || !ce)
    else $error("open missing on feedback error");
  chk_abort_tune: assert property (@(posedge aclk) disable iff (!aresetn) // [R17]
    ce && $rose(s_q.manual) && $past(autotune_active) |-> autotune_abort)
    else $error("autotune not aborted");

  // manual value on the output, its range, and manual kept on power restore
  chk_manual_follow: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
    ce && s_q.manual && !s_q.ramping && s_d.manual |=> mv_out == $past(s_q.man_mv))
    else $error("manual mv not on output");
  chk_prog_priority: assert property (@(posedge aclk) disable iff (!aresetn) // [R16]
    ce && program_reset && s_q.manual && !s_q.ramping && s_d.manual |=>
    mv_out == $past(s_q.man_mv)) else $error("program reset overrode manual mv");
  chk_man_range: assert property (@(posedge aclk) disable iff (!aresetn) // [R12]
    ce && do_write && s_q.aw_addr == MANMV_OFS && s_q.manual && !key_mode |=>
    s_q.man_mv >= $past(lo_bound) && s_q.man_mv <= $past(hi_bound))
    else $error("manual mv outside its range");
  chk_power_hold: assert property (@(posedge aclk) disable iff (!aresetn) // [R6]
    ce && power_restored && s_q.manual && want_manual |=> manual_active)
    else $error("manual lost on power restore");

  // valve drives from keys and on feedback error
  chk_key_open: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
    ce && s_q.manual && !err_now && key_mode && s_q.ctrl[CTRL_KEY_UP] &&
    !s_q.ctrl[CTRL_KEY_DOWN] |=> valve_open) else $error("up key did not open");
  chk_err_close: assert property (@(posedge aclk) disable iff (!aresetn) // [R9]
    ce && s_q.ctrl[CTRL_VALVE] && s_q.manual && err_now &&
    !s_q.ctrl[CTRL_LIMIT_ENABLE] && s_q.man_mv <= MV_ZERO |=> valve_close)
    else $error("close missing on feedback error");
  chk_lim_open: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
    ce && s_q.ctrl[CTRL_VALVE] && s_q.manual && err_now && s_q.ctrl[CTRL_LIMIT_ENABLE] &&
    s_q.man_mv == s_q.lim_hi && s_q.lim_hi != s_q.lim_lo |=> valve_open)
    else $error("open missing at upper limit");
  chk_fault_idle: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
    ce && s_q.ctrl[CTRL_VALVE] && s_q.manual && err_now && s_q.ctrl[CTRL_LIMIT_ENABLE] &&
    s_q.man_mv != s_q.lim_hi && s_q.man_mv != s_q.lim_lo |=> !valve_open && !valve_close)
    else $error("drive on between limits");

  // main scenarios
  cov_enter_manual: cover property (@(posedge aclk) $rose(manual_active));
  cov_ramp_done: cover property (@(posedge aclk) $fell(s_q.ramping));
  cov_err_close: cover property (@(posedge aclk) valve_close && err_now);
  cov_key_open: cover property (@(posedge aclk) valve_open && !err_now);
  cov_lim_open: cover property (@(posedge aclk) valve_open && err_now && s_q.ctrl[CTRL_LIMIT_ENABLE]);
endmodule

// >>> verif/valve_model.sv
// motorised valve model: travels on the open/close drives, reports a
// position feedback fault on request. assumes drives in the aclk domain.
`timescale 1ns/10ps
module valve_model (
  // clock and reset
  input  wire logic  aclk,
  input  wire logic  aresetn,
  // drives from the controller
  input  wire logic  valve_open,
  input  wire logic  valve_close,
  // bench control and feedback
  input  wire logic  fail_req,
  output logic       feedback_err,
  output logic [9:0] position
);
  // ==========================================================
  // travel with end stops; opposed drives hold the spindle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      position     <= 10'h000;
      feedback_err <= 1'b0;
    end else begin
      feedback_err <= fail_req; // broken wiper, asserted by the bench
      if (valve_open && !valve_close && position != 10'h3E7) begin
        position <= position + 10'h001;
      end else if (valve_close && !valve_open && position != 10'h000) begin
        position <= position - 10'h001;
      end
    end
  end
endmodule

// >>> verif/manual_mv_control_tb.sv
// testbench for manual mv control: register sequences over axi4-lite.
// assumes the valve model on the drives and the package constants.
`timescale 1ns/10ps
module manual_mv_control_tb;
  import manual_mv_pkg::*;
  // ==========================================================
  // signals
  logic               aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]         awaddr, araddr;
  logic [31:0]        wdata, rdata;
  logic [1:0]         bresp, rresp, resp;
  logic               awready, wready, bvalid, arready, rvalid, fb_err, fail_req;
  logic signed [15:0] auto_mv, mv_out, frozen;
  logic               power_restored, program_reset, autotune_active, valve_open;
  logic               valve_close, manual_active, display_return_en, autotune_abort;
  logic               segment_timer_run, ce;
  int                 mismatches = 0, total_checks = 0, abort_cnt = 0, i;
  // ctrl, written mv, expected mv
  logic signed [31:0] mtab [6][3] = '{'{32'h00F, 2000, 1000}, '{32'h00F, -100, 0},
    '{32'h007, 2000, 1050}, '{32'h007, -100, -50}, '{32'h047, -2000, -1050},
    '{32'h047, 600, 600}};
  // ctrl, mv, open, close
  logic [31:0]        vtab [6][4] = '{'{32'h097, 1000, 1, 0}, '{32'h097, 0, 0, 1},
    '{32'h097, 500, 0, 0}, '{32'h09F, 800, 1, 0}, '{32'h09F, 100, 0, 1},
    '{32'h09F, 500, 0, 0}};

  manual_mv_control i_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .auto_mv(auto_mv),
    .feedback_err_pin(fb_err), .power_restored(power_restored),
    .program_reset(program_reset), .autotune_active(autotune_active),
    .mv_out(mv_out), .valve_open(valve_open), .valve_close(valve_close),
    .manual_active(manual_active), .display_return_en(display_return_en),
    .autotune_abort(autotune_abort), .segment_timer_run(segment_timer_run));
  valve_model i_valve (.aclk(aclk), .aresetn(aresetn), .valve_open(valve_open),
    .valve_close(valve_close), .fail_req(fail_req), .feedback_err(fb_err), .position());

  // ==========================================================
  // clock, abort pulse counter, watchdog
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) if (autotune_abort === 1'b1) abort_cnt++;
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++; // hang counts as a failure
    stop_test();
  end

  // ==========================================================
  // helpers
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // aw and w offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_t, w_t;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    aw_t = 1'b0;
    w_t  = 1'b0;
    while (!(aw_t && w_t)) begin
      @(posedge aclk);
      if (!aw_t && awready === 1'b1) begin
        aw_t = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_t && wready === 1'b1) begin
        w_t = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string name);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    @(posedge aclk);
    while (arready !== 1'b1) @(posedge aclk);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    resp = rresp;
    rready <= 1'b0;
    chk(name, rdata, exp);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, fail_req} = 7'h00;
    {power_restored, program_reset, ce} = 3'h1;
    {awaddr, araddr, wdata} = '0;
    auto_mv = 16'sh012C;
    autotune_active = 1'b1;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rdchk(CTRL_OFS, 32'h0000_000A, "ctrl");
    rdchk(LIMIT_OFS, 32'h03E8_0000, "limit");
    rdchk(8'h10, 32'h0, "unmapped");
    chk("rresp", resp, RESP_SLVERR);
    wr(STATUS_OFS, 32'h1);
    chk("bresp", resp, RESP_SLVERR);
    tick(400);
    chk("auto mv", 32'(mv_out), 32'd300);
    // refused entries: on/off control, then select disabled
    wr(CTRL_OFS, 32'h00B);
    tick(3);
    chk("manual", manual_active, 1'b0);
    wr(CTRL_OFS, 32'h00D);
    tick(3);
    chk("manual", manual_active, 1'b0);
    wr(CTRL_OFS, 32'h00F);
    tick(3);
    chk("manual", manual_active, 1'b1);
    chk("abort", abort_cnt, 32'd1);
    chk("disp", display_return_en, 1'b0);
    chk("segment", segment_timer_run, 1'b1);
    rdchk(MANMV_OFS, 32'd300, "seed");
    autotune_active <= 1'b0;
    // limits, ranges and immediate effect of manual writes
    for (i = 0; i < 6; i++) begin
      wr(CTRL_OFS, mtab[i][0]);
      wr(MANMV_OFS, mtab[i][1]);
      tick(3);
      chk("mv_out", 32'(mv_out), mtab[i][2]);
      rdchk(MANMV_OFS, mtab[i][2], "manmv");
    end
    @(posedge aclk);
    program_reset <= 1'b1;
    tick(3);
    chk("mv prog rst", 32'(mv_out), 32'd600);
    chk("segment", segment_timer_run, 1'b0);
    @(posedge aclk);
    program_reset  <= 1'b0;
    power_restored <= 1'b1;
    @(posedge aclk);
    power_restored <= 1'b0;
    tick(3);
    chk("manual", manual_active, 1'b1);
    rdchk(MANMV_OFS, 32'd600, "held mv");
    // back to auto: starts near the old value, then settles
    wr(CTRL_OFS, 32'h00E);
    tick(3);
    chk("no step", mv_out > 16'sd500, 1'b1);
    // clock enable low must freeze the ramp
    @(posedge aclk);
    ce <= 1'b0;
    tick(2);
    frozen = mv_out;
    tick(8);
    chk("frozen", 32'(mv_out), 32'(frozen));
    @(posedge aclk);
    ce <= 1'b1;
    tick(400);
    chk("ramped", 32'(mv_out), 32'd300);
    wr(CTRL_OFS, 32'h00F);
    // key driven valve: up, down, both, none
    for (i = 0; i < 4; i++) begin
      wr(CTRL_OFS, 32'h0A7 | (i[1:0] == 2'd3 ? 32'h0 : 32'(i + 1) << 8));
      tick(3);
      chk("open", valve_open, i == 0);
      chk("close", valve_close, i == 1);
    end
    wr(MANMV_OFS, 32'd900);
    rdchk(MANMV_OFS, 32'd300, "key mode mv");
    wr(CTRL_OFS, 32'h097);
    wr(MANMV_OFS, 32'd900);
    rdchk(MANMV_OFS, 32'd900, "direct mv");
    // feedback fault fallback, limit off then on (limits 100..800)
    wr(LIMIT_OFS, 32'h0320_0064);
    @(posedge aclk);
    fail_req <= 1'b1;
    tick(20);
    for (i = 0; i < 6; i++) begin
      wr(CTRL_OFS, vtab[i][0]);
      wr(MANMV_OFS, vtab[i][1]);
      tick(5);
      chk("fb open", valve_open, vtab[i][2][0]);
      chk("fb close", valve_close, vtab[i][3][0]);
    end
    // manual, feedback error, out_mv 500 low byte at [15:8]
    rdchk(STATUS_OFS, 32'h0000_F411, "status");
    chk("abort", abort_cnt, 32'd1);
    stop_test();
  end
endmodule
